/* File: bench/oad_decoder_assertions.sv */
`timescale 1ns/100ps
module oad_decoder_assertions (
	input wire logic        clk,
	input wire logic        rst_b,
	input wire logic        byte_valid,
	input wire logic [7:0]  byte_data,
	input wire logic        byte_ready,
	input wire logic        op_start,
	input wire logic        done,
	input wire logic        is_reg_operand,
	input wire logic        bus_lock,
	input wire logic [15:0] effective_address,
	input wire logic [19:0] phys_address,
	input wire logic [1:0]  seg_used,
	input wire logic [15:0] extra_segment,
	input wire logic [15:0] code_segment,
	input wire logic [15:0] stack_segment,
	input wire logic [15:0] data_segment
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	wire tk = byte_valid && byte_ready;
	wire [1:0] md = byte_data[7:6];
	wire [15:0] sg = seg_used == 2'h0 ? extra_segment : seg_used == 2'h1 ? code_segment
		: seg_used == 2'h2 ? stack_segment : data_segment;
	// disp bytes may look like a lock byte, so only idle bytes count
	logic busy_r;
	always_ff @(posedge clk) begin
		busy_r <= !rst_b ? 1'b0 : op_start ? 1'b1 : done ? 1'b0 : busy_r;
	end
	sequence s_start; op_start && byte_ready && !byte_valid; endsequence
	sequence s_calc; !byte_ready [*5] ##1 done; endsequence
	done_pulse_a: assert property (done |=> !done)
		else $error("done too long");
	reg_mode_a: assert property (s_start ##1 (tk && md == 2'h3) |=> done && is_reg_operand)
		else $error("register mode wrong");
	no_disp_a: assert property (s_start ##1 (tk && md == 2'h0 && byte_data[2:0] != 3'h6) |=> s_calc)
		else $error("no disp timing wrong");
	disp_byte_a: assert property (s_start ##1 (tk && md == 2'h1) ##1 tk |=> s_calc)
		else $error("disp8 timing wrong");
	disp_word_a: assert property (s_start ##1 (tk && md == 2'h2) ##1 tk ##1 tk |=> s_calc)
		else $error("disp16 timing wrong");
	direct_addr_a: assert property (s_start ##1 (tk && md == 2'h0 && byte_data[2:0] == 3'h6)
		##1 tk ##1 tk |=> s_calc)
		else $error("direct timing wrong");
	lock_stall_a: assert property (tk && byte_data == 8'hf0 && !op_start && !busy_r
		|=> !byte_ready [*2] ##1 byte_ready)
		else $error("lock stall wrong");
	lock_hold_a: assert property (bus_lock && !done |=> bus_lock || done)
		else $error("lock dropped");
	phys_sum_a: assert property (done && !is_reg_operand
		|-> phys_address == {sg, 4'h0} + {4'h0, effective_address})
		else $error("physical address wrong");
endmodule

/* File: bench/oad_feed.sv */
`timescale 1ns/100ps
module oad_feed (
	input  wire logic  clk,
	input  wire logic  byte_ready,
	output logic       byte_valid = 1'b0,
	output logic [7:0] byte_data = 8'h00
);
	logic [7:0] q[$];
	// one process pops and presents, so the next byte follows at the same edge
	// an empty queue shows a toggling pattern, the old byte and its complement in turn
	always @(posedge clk) begin
		if (byte_valid && byte_ready) void'(q.pop_front());
		byte_valid <= q.size() != 0;
		byte_data <= q.size() != 0 ? q[0] : ~byte_data;
	end
endmodule

/* File: bench/operand_address_decoder_bench.sv */
`timescale 1ns/100ps
module operand_address_decoder_bench;
	logic        clk = 0, rst_b = 0, op_start = 0, op_word = 0, op_string_dst = 0;
	logic        op_mem_xfers = 0, reg_wr_en = 0, byte_valid, byte_ready, done;
	logic        is_reg_operand, bus_lock, prefix_seen;
	logic [2:0]  reg_wr_sel = 0, reg_sel_r, rm_reg_sel_r;
	logic [15:0] reg_wr_data = 0, rv[8], sv[4], effective_address;
	logic [7:0]  byte_data;
	logic [19:0] phys_address;
	logic [1:0]  seg_used;
	logic [3:0]  extra_cycles;
	logic [43:0] eq[$];
	logic [43:0] got_w, exp_w;
	int          num_errors = 0, total_checks = 0, cyc = 0, bi[8] = '{3, 3, 5, 5, 6, 7, 5, 3};
	wire [15:0]  extra_segment = sv[0], code_segment = sv[1];
	wire [15:0]  stack_segment = sv[2], data_segment = sv[3];
	oad_decoder i_oad_decoder (
		.clk               (clk),
		.rst_b             (rst_b),
		.byte_valid        (byte_valid),
		.byte_data         (byte_data),
		.byte_ready        (byte_ready),
		.op_start          (op_start),
		.op_word           (op_word),
		.op_string_dst     (op_string_dst),
		.op_mem_xfers      (op_mem_xfers),
		.reg_wr_en         (reg_wr_en),
		.reg_wr_sel        (reg_wr_sel),
		.reg_wr_data       (reg_wr_data),
		.extra_segment     (extra_segment),
		.code_segment      (code_segment),
		.stack_segment     (stack_segment),
		.data_segment      (data_segment),
		.done              (done),
		.is_reg_operand    (is_reg_operand),
		.reg_sel_r         (reg_sel_r),
		.rm_reg_sel_r      (rm_reg_sel_r),
		.effective_address (effective_address),
		.phys_address      (phys_address),
		.seg_used          (seg_used),
		.extra_cycles      (extra_cycles),
		.bus_lock          (bus_lock),
		.prefix_seen       (prefix_seen)
	);
	oad_feed i_oad_feed (
		.clk        (clk),
		.byte_ready (byte_ready),
		.byte_valid (byte_valid),
		.byte_data  (byte_data)
	);
	initial forever #5 clk = ~clk;
	task automatic chk(input logic [43:0] g, input logic [43:0] e);
		total_checks++;
		if (g !== e) begin
			num_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wrap_up;
		$display("errors %0d checks %0d", num_errors, total_checks);
		if (num_errors == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic send(input logic [7:0] b, input int n);
		// queue is filled between edges so the feed sees it at a known edge
		@(negedge clk);
		i_oad_feed.q.push_back(b);
		repeat (n) @(posedge clk);
	endtask
	task automatic op(input logic [1:0] md, input logic [2:0] rm);
		logic [15:0] d, ea;
		logic [2:0]  rg;
		logic [1:0]  sg, s;
		logic        ov, sd, w, mx, lk;
		d = 16'($urandom);
		rg = 3'($urandom);
		sg = 2'($urandom);
		{ov, sd, w, mx, lk} = 5'($urandom);
		if (lk) send(8'hf0, 4);
		if (ov) send({3'h1, sg, 3'h6}, 2);
		if (md == 2'h0 && rm == 3'h6) ea = d;
		else ea = (md == 2'h1 ? {{8{d[7]}}, d[7:0]} : md == 2'h2 ? d : 16'h0)
			+ rv[bi[rm]] + (rm < 3'h4 ? rv[rm[0] ? 7 : 6] : 16'h0);
		s = sd ? 2'h0 : ov ? sg
			: (rm == 3'h2 || rm == 3'h3 || rm == 3'h6 && md != 2'h0) ? 2'h2 : 2'h3;
		eq.push_back(md == 2'h3 ? {1'b1, 37'h0, rg, rm}
			: {2'h0, (w && mx) ? 4'h4 : 4'h0, s, {sv[s], 4'h0} + {4'h0, ea}, ea});
		{op_start, op_word, op_string_dst, op_mem_xfers} <= {1'b1, w, sd, mx};
		@(negedge clk);
		chk(prefix_seen, ov);
		// bytes appear at the same edge that takes op_start, never while still idle
		i_oad_feed.q.push_back({md, rg, rm});
		if (md == 2'h1 || md == 2'h2 || md == 2'h0 && rm == 3'h6) i_oad_feed.q.push_back(d[7:0]);
		if (md == 2'h2 || md == 2'h0 && rm == 3'h6) i_oad_feed.q.push_back(d[15:8]);
		@(posedge clk);
		op_start <= 0;
		@(negedge clk);
		chk(bus_lock, lk);
		for (int i = 0; i < 20 && done !== 1'b1; i++) @(negedge clk);
		@(posedge clk);
	endtask
	always @(negedge clk) begin
		if (done === 1'b1) begin
			// reg operands compare selectors, memory ones the address result
			got_w = is_reg_operand ? {1'b1, 37'h0, reg_sel_r, rm_reg_sel_r}
				: {2'h0, extra_cycles, seg_used, phys_address, effective_address};
			exp_w = eq.size() ? eq.pop_front() : '1;
			chk(got_w, exp_w);
		end
		cyc++;
		if (cyc == 5000) begin
			num_errors++;
			wrap_up;
		end
	end
	initial begin
		void'($urandom(47289));
		foreach (sv[i]) sv[i] = 16'($urandom);
		foreach (rv[i]) rv[i] = 16'($urandom);
		repeat (6) @(posedge clk);
		rst_b <= 1;
		@(negedge clk);
		chk({done, byte_ready, seg_used}, 4'h7);
		@(posedge clk);
		foreach (rv[i]) begin
			{reg_wr_en, reg_wr_sel, reg_wr_data} <= {1'b1, 3'(i), rv[i]};
			@(posedge clk);
		end
		reg_wr_en <= 0;
		@(posedge clk);
		for (int k = 0; k < 64; k++) op(2'(k), 3'(k / 4));
		repeat (3) @(posedge clk);
		// every noted operand must have been answered
		chk(44'(eq.size()), 44'h0);
		wrap_up;
	end
endmodule
bind oad_decoder oad_decoder_assertions i_chk (
	.clk               (clk),
	.rst_b             (rst_b),
	.byte_valid        (byte_valid),
	.byte_data         (byte_data),
	.byte_ready        (byte_ready),
	.op_start          (op_start),
	.done              (done),
	.is_reg_operand    (is_reg_operand),
	.bus_lock          (bus_lock),
	.effective_address (effective_address),
	.phys_address      (phys_address),
	.seg_used          (seg_used),
	.extra_segment     (extra_segment),
	.code_segment      (code_segment),
	.stack_segment     (stack_segment),
	.data_segment      (data_segment)
);

/* File: verilog/oad_decoder.sv */
`timescale 1ns/100ps
`include "oad_defines.svh"
// Behaviour
// - mode 11 makes r/m a second register selector, no memory address.
// - mode 00 uses zero displacement, no displacement bytes, except direct.
// - mode 01 takes one byte, sign-extended to 16 bits.
// - mode 10 takes two bytes, later byte is the upper half.
// - r/m 000-011 add base/frame with source/destination index pairs.
// - r/m 100-111 add source, destination, frame pointer, base register.
// - mode 00 r/m 110 is a direct 16-bit address.
// - displacement bytes follow the second byte, before immediate data.
// - effective address calculation takes 4 clocks in every memory mode.
// - override prefix 001ss110 picks extra, code, stack, data segment.
// - register field picks word registers, or low then high bytes.
// - frame pointer addressing defaults to the stack segment.
// - string destinations always use extra segment, override ignored.
// - word operations add 4 clocks per memory transfer.
// - byte f0 is a 2-clock lock prefix locking the next instruction.
module oad_decoder
	import oad_pkg::*;
#(
	parameter int W  = 16,
	parameter int PA = 20
) (
	input  wire logic          clk,
	input  wire logic          rst_b,
	input  wire logic          byte_valid,
	input  wire logic [7:0]    byte_data,
	output logic               byte_ready,
	input  wire logic          op_start,
	input  wire logic          op_word,
	input  wire logic          op_string_dst,
	input  wire logic          op_mem_xfers,
	input  wire logic          reg_wr_en,
	input  wire logic [2:0]    reg_wr_sel,
	input  wire logic [W-1:0]  reg_wr_data,
	input  wire logic [W-1:0]  extra_segment,
	input  wire logic [W-1:0]  code_segment,
	input  wire logic [W-1:0]  stack_segment,
	input  wire logic [W-1:0]  data_segment,
	output logic               done,
	output logic               is_reg_operand,
	output logic [2:0]         reg_sel_r,
	output logic [2:0]         rm_reg_sel_r,
	output logic [W-1:0]       effective_address,
	output logic [PA-1:0]      phys_address,
	output logic [1:0]         seg_used,
	output logic [3:0]         extra_cycles,
	output logic               bus_lock,
	output logic               prefix_seen
);
	if (W != 16 || PA != 20) begin : g_bad_width
		$error("oad_decoder: unsupported widths");
	end
	localparam logic [2:0] EA_CNT   = 3'(`OAD_EA_CYCLES);
	localparam logic [2:0] LOCK_CNT = 3'(`OAD_LOCK_CYCLES);

	oad_state_e   st_r, st_nxt;
	logic [1:0]   mod_r, mod_nxt;
	logic [2:0]   rm_r, rm_nxt, reg_r, reg_nxt;
	logic [7:0]   dlo_r, dlo_nxt;
	logic [W-1:0] disp_r, disp_nxt;
	logic [2:0]   cnt_r, cnt_nxt;
	logic         ovr_r, ovr_nxt;
	logic [1:0]   ovs_r, ovs_nxt;
	logic         lock_r, lock_nxt;
	logic         lockarm_r, lockarm_nxt;
	logic [W-1:0] ea_r, ea_nxt;
	logic [PA-1:0] pa_r, pa_nxt;
	logic [1:0]   seg_r, seg_nxt;
	logic [3:0]   xc_r, xc_nxt;
	logic         word_r, word_nxt, sdst_r, sdst_nxt;
	logic         done_r, done_nxt;

	// the single regfile read port is sequenced: base operand then index operand
	logic [2:0]   rd_sel;
	logic [W-1:0] rd_data;
	logic [W-1:0] opa_r, opa_nxt;
	logic         two_reg, uses_frame;
	logic [W-1:0] seg_val;
	logic         take;

	oad_regfile #(.W(W)) u_regs (
		.clk     (clk),
		.wr_en   (reg_wr_en),
		.wr_sel  (reg_wr_sel),
		.wr_data (reg_wr_data),
		.rd_sel  (rd_sel),
		.rd_word (1'b1),
		.rd_data (rd_data)
	);

	assign take = byte_valid && byte_ready;
	assign two_reg = !rm_r[2];
	assign uses_frame = (two_reg && rm_r[1]) ||
		(rm_r == `OAD_RM_DIRECT && mod_r != `OAD_MOD_NODISP);

	always_comb begin
		byte_ready = (st_r == OAD_IDLE) || (st_r == OAD_MODRM) ||
			(st_r == OAD_DLO) || (st_r == OAD_DHI);
		// register codes: 3 base, 5 frame, 6 source, 7 destination
		rd_sel = 3'h3;
		case (rm_r)
			3'h0, 3'h1: rd_sel = (cnt_r == EA_CNT) ? 3'h3 : {2'h3, rm_r[0]};
			3'h2, 3'h3: rd_sel = (cnt_r == EA_CNT) ? 3'h5 : {2'h3, rm_r[0]};
			3'h4: rd_sel = 3'h6;
			3'h5: rd_sel = 3'h7;
			3'h6: rd_sel = 3'h5;
			3'h7: rd_sel = 3'h3;
			default: rd_sel = 3'h3;
		endcase
		case (seg_r)
			OAD_SEG_EXTRA: seg_val = extra_segment;
			OAD_SEG_CODE:  seg_val = code_segment;
			OAD_SEG_STACK: seg_val = stack_segment;
			default:       seg_val = data_segment;
		endcase
	end

	always_comb begin
		st_nxt = st_r;
		mod_nxt = mod_r;
		rm_nxt = rm_r;
		reg_nxt = reg_r;
		dlo_nxt = dlo_r;
		disp_nxt = disp_r;
		cnt_nxt = cnt_r;
		ovr_nxt = ovr_r;
		ovs_nxt = ovs_r;
		lock_nxt = lock_r;
		lockarm_nxt = lockarm_r;
		ea_nxt = ea_r;
		pa_nxt = pa_r;
		seg_nxt = seg_r;
		xc_nxt = xc_r;
		word_nxt = word_r;
		sdst_nxt = sdst_r;
		opa_nxt = opa_r;
		done_nxt = 1'b0;
		case (st_r)
			OAD_IDLE: begin
				if (take && byte_data == `OAD_LOCK_OP) begin
					lockarm_nxt = 1'b1;
					cnt_nxt = LOCK_CNT;
					st_nxt = OAD_LOCKW;
				end else if (take && (byte_data & `OAD_SEGOV_MASK) == `OAD_SEGOV_PAT) begin
					ovr_nxt = 1'b1;
					ovs_nxt = byte_data[`OAD_SEG_LSB +: 2];
				end else if (op_start) begin
					word_nxt = op_word;
					sdst_nxt = op_string_dst;
					xc_nxt = (op_word && op_mem_xfers) ? 4'(`OAD_WORD_XFER) : 4'h0;
					lock_nxt = lockarm_r;
					lockarm_nxt = 1'b0;
					st_nxt = OAD_MODRM;
				end
			end
			OAD_LOCKW: begin
				cnt_nxt = cnt_r - 3'h1;
				if (cnt_r == 3'h1) begin
					st_nxt = OAD_IDLE;
				end
			end
			OAD_MODRM: begin
				if (take) begin
					mod_nxt = byte_data[7:6];
					reg_nxt = byte_data[5:3];
					rm_nxt = byte_data[2:0];
					disp_nxt = '0;
					cnt_nxt = EA_CNT;
					if (byte_data[7:6] == `OAD_MOD_REG) begin
						// no address to form: one done pulse, prefixes released here
						st_nxt = OAD_IDLE;
						done_nxt = 1'b1;
						ovr_nxt = 1'b0;
						lock_nxt = 1'b0;
					end else if (byte_data[7:6] == `OAD_MOD_NODISP) begin
						st_nxt = (byte_data[2:0] == `OAD_RM_DIRECT) ? OAD_DLO : OAD_CALC;
					end else begin
						st_nxt = OAD_DLO;
					end
				end
			end
			OAD_DLO: begin
				if (take) begin
					dlo_nxt = byte_data;
					if (mod_r == `OAD_MOD_DISP8) begin
						disp_nxt = {{8{byte_data[7]}}, byte_data};
						st_nxt = OAD_CALC;
					end else begin
						st_nxt = OAD_DHI;
					end
				end
			end
			OAD_DHI: begin
				if (take) begin
					disp_nxt = {byte_data, dlo_r};
					st_nxt = OAD_CALC;
				end
			end
			OAD_CALC: begin
				// fixed 4 clocks regardless of mode
				cnt_nxt = cnt_r - 3'h1;
				if (cnt_r == EA_CNT - 3'h1) begin
					opa_nxt = rd_data;
				end
				if (cnt_r == 3'h1) begin
					if (mod_r == `OAD_MOD_NODISP && rm_r == `OAD_RM_DIRECT) begin
						ea_nxt = disp_r;
					end else if (two_reg) begin
						ea_nxt = W'(opa_r + rd_data + disp_r);
					end else begin
						ea_nxt = W'(opa_r + disp_r);
					end
					if (sdst_r) begin
						seg_nxt = OAD_SEG_EXTRA;
					end else if (ovr_r) begin
						seg_nxt = ovs_r;
					end else if (uses_frame) begin
						seg_nxt = OAD_SEG_STACK;
					end else begin
						seg_nxt = OAD_SEG_DATA;
					end
					st_nxt = OAD_DONE;
				end
			end
			OAD_DONE: begin
				pa_nxt = PA'({seg_val, {`OAD_SEG_SHIFT{1'b0}}}) + PA'(ea_r);
				done_nxt = 1'b1;
				ovr_nxt = 1'b0;
				lock_nxt = 1'b0;
				st_nxt = OAD_IDLE;
			end
			default: st_nxt = OAD_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			st_r <= OAD_IDLE;
			mod_r <= 2'h0;
			rm_r <= 3'h0;
			reg_r <= 3'h0;
			dlo_r <= 8'h00;
			disp_r <= '0;
			cnt_r <= 3'h0;
			ovr_r <= 1'b0;
			ovs_r <= 2'h0;
			lock_r <= 1'b0;
			lockarm_r <= 1'b0;
			ea_r <= '0;
			pa_r <= '0;
			seg_r <= OAD_SEG_DATA;
			xc_r <= 4'h0;
			word_r <= 1'b0;
			sdst_r <= 1'b0;
			opa_r <= '0;
			done_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			mod_r <= mod_nxt;
			rm_r <= rm_nxt;
			reg_r <= reg_nxt;
			dlo_r <= dlo_nxt;
			disp_r <= disp_nxt;
			cnt_r <= cnt_nxt;
			ovr_r <= ovr_nxt;
			ovs_r <= ovs_nxt;
			lock_r <= lock_nxt;
			lockarm_r <= lockarm_nxt;
			ea_r <= ea_nxt;
			pa_r <= pa_nxt;
			seg_r <= seg_nxt;
			xc_r <= xc_nxt;
			word_r <= word_nxt;
			sdst_r <= sdst_nxt;
			opa_r <= opa_nxt;
			done_r <= done_nxt;
		end
	end

	assign done = done_r;
	assign is_reg_operand = (mod_r == `OAD_MOD_REG);
	assign reg_sel_r = reg_r;
	assign rm_reg_sel_r = rm_r;
	assign effective_address = ea_r;
	assign phys_address = pa_r;
	assign seg_used = seg_r;
	assign extra_cycles = xc_r;
	assign bus_lock = lock_r;
	assign prefix_seen = ovr_r;
endmodule

/* File: verilog/oad_defines.svh */
`ifndef OAD_DEFINES_SVH
`define OAD_DEFINES_SVH
`define OAD_MOD_NODISP   2'b00
`define OAD_MOD_DISP8    2'b01
`define OAD_MOD_DISP16   2'b10
`define OAD_MOD_REG      2'b11
`define OAD_RM_DIRECT    3'b110
`define OAD_LOCK_OP      8'hf0
`define OAD_SEGOV_MASK   8'he7
`define OAD_SEGOV_PAT    8'h26
`define OAD_SEG_LSB      3
`define OAD_EA_TIME_NS   40
`define OAD_CLK_NS       10
`define OAD_EA_CYCLES    ((`OAD_EA_TIME_NS + `OAD_CLK_NS - 1) / `OAD_CLK_NS)
`define OAD_LOCK_CYCLES  2
`define OAD_WORD_XFER    4
`define OAD_SEG_SHIFT    4
`endif

/* File: verilog/oad_pkg.sv */
package oad_pkg;
	typedef enum logic [1:0] {
		OAD_SEG_EXTRA = 2'h0,
		OAD_SEG_CODE  = 2'h1,
		OAD_SEG_STACK = 2'h2,
		OAD_SEG_DATA  = 2'h3
	} oad_seg_e;
	typedef enum logic [2:0] {
		OAD_IDLE  = 3'h0,
		OAD_MODRM = 3'h1,
		OAD_DLO   = 3'h3,
		OAD_DHI   = 3'h2,
		OAD_CALC  = 3'h6,
		OAD_DONE  = 3'h7,
		OAD_LOCKW = 3'h5
	} oad_state_e;
endpackage

/* File: verilog/oad_regfile.sv */
`timescale 1ns/100ps
// eight word registers; byte codes map to low/high halves
module oad_regfile #(
	parameter int W = 16
) (
	input  wire logic         clk,
	input  wire logic         wr_en,
	input  wire logic [2:0]   wr_sel,
	input  wire logic [W-1:0] wr_data,
	input  wire logic [2:0]   rd_sel,
	input  wire logic         rd_word,
	output logic [W-1:0]      rd_data
);
	if (W != 16) begin : g_bad_width
		$error("oad_regfile: width must be 16");
	end
	logic [W-1:0] mem [8];
	logic [W-1:0] word_v;
	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_sel] <= wr_data;
		end
	end
	always_comb begin
		word_v = mem[{1'b0, rd_sel[1:0]}];
		if (rd_word) begin
			word_v = mem[rd_sel];
		end else if (rd_sel[2]) begin
			word_v = {8'h00, word_v[15:8]};
		end else begin
			word_v = {8'h00, word_v[7:0]};
		end
	end
	always_ff @(posedge clk) begin
		rd_data <= word_v;
	end
endmodule
